// ### src/pcrc_pkg.sv
// Constants and types shared by the programmable checksum generator.
//
// Functional notes
// - Software picks CCITT, CRC-16 or CRC-32 generator polynomial.
// - CCITT selection yields a 16-bit remainder, terms x16, x12, x5, 1.
// - CRC-16 selection yields a 16-bit remainder, terms x16, x15, x2, 1.
// - CRC-32 selection yields a 32-bit remainder using the standard terms.
// - Input bit reverse, input invert, sum reverse, sum invert are separate.
// - A written seed becomes the starting remainder of the next checksum.
// - Writes of 8, 16 or 32 bits fold every written byte into the sum.
// - One byte per cycle: one, two or four cycles per write.
// - Processor or DMA may stream data writes back to back.
`default_nettype none
package pcrc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_SEED = 12'h004;
    localparam logic [11:0] OFS_SUM  = 12'h008;
    localparam logic [11:0] OFS_DATA = 12'h00c;

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_IN_REV  = 2;
    localparam int MODE_IN_INV  = 3;
    localparam int MODE_OUT_REV = 4;
    localparam int MODE_OUT_INV = 5;
    localparam int MODE_WIDTH   = 6;

    // ------------------------------------------------------------------
    // Reset values and polynomials
    // ------------------------------------------------------------------
    localparam logic [5:0]  RST_MODE  = 6'h00;
    localparam logic [31:0] RST_SUM   = 32'h0000_0000;
    localparam logic [31:0] POLY_CCITT = 32'h0000_1021;
    localparam logic [31:0] POLY_C16   = 32'h0000_8005;
    localparam logic [31:0] POLY_C32   = 32'h04c1_1db7;

    typedef enum logic [1:0] {
        SEL_CCITT = 2'b00,
        SEL_C16   = 2'b01,
        SEL_C32   = 2'b10,
        SEL_RSVD  = 2'b11
    } pcrc_sel_t;

endpackage : pcrc_pkg
`default_nettype wire

// ### src/pcrc_step.sv
// One-byte remainder update, MSB first, for 16- or 32-bit polynomials.
`timescale 1ns/100ps
`default_nettype none
module pcrc_step
(
    // Current state and byte
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_in,
    // Polynomial choice
    input  wire logic        wide,
    input  wire logic [31:0] poly,
    // Next state
    output logic      [31:0] crc_out
);

    // ------------------------------------------------------------------
    // Shift loop
    // ------------------------------------------------------------------

    // A 16-bit remainder is aligned to the top so one loop serves both.
    always_comb
    begin
        logic [31:0] acc;
        logic [31:0] pl;
        logic        fb;
        acc = wide ? crc_in : {crc_in[15:0], 16'h0000};
        pl  = wide ? poly : {poly[15:0], 16'h0000};
        fb  = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            fb  = acc[31] ^ data_in[i];
            acc = {acc[30:0], 1'b0} ^ (fb ? pl : 32'h0000_0000);
        end
        crc_out = wide ? acc : {16'h0000, acc[31:16]};
    end

endmodule : pcrc_step
`default_nettype wire

// ### src/pcrc_top.sv
// APB-attached programmable checksum generator with byte-serial engine.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pcrc_top
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction : hit

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7-i];
    endfunction : rev8

    function automatic logic [31:0] rev32(input logic [31:0] v);
        for (int i = 0; i < 32; i++)
            rev32[i] = v[31-i];
    endfunction : rev32

    function automatic logic [2:0] nbytes(input logic [3:0] s);
        nbytes = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]);
    endfunction : nbytes

    function automatic logic [1:0] first_lane(input logic [3:0] s);
        first_lane = s[0] ? 2'd0 : s[1] ? 2'd1 : s[2] ? 2'd2 : 2'd3;
    endfunction : first_lane

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [5:0]  mode;
    logic [31:0] crc;
    logic [31:0] shreg;
    logic [2:0]  cnt;
    logic [31:0] rdata;
    logic [5:0]  next_mode;
    logic [31:0] next_crc;
    logic [31:0] next_shreg;
    logic [2:0]  next_cnt;
    logic [31:0] next_rdata;

    pcrc_pkg::pcrc_sel_t sel;
    logic        wide;
    logic [31:0] poly;
    logic [7:0]  cur_byte;
    logic [31:0] step_out;
    logic [31:0] sum_view;
    logic [31:0] sum_rev;
    logic        acc_ph;
    logic        mapped;
    logic        wr_data;
    logic        wr_seed;
    logic        wr_mode;

    // ------------------------------------------------------------------
    // APB decode and handshake
    // ------------------------------------------------------------------

    assign acc_ph = PSEL && PENABLE;
    assign mapped = hit(PADDR, pcrc_pkg::OFS_MODE)
                 || hit(PADDR, pcrc_pkg::OFS_SEED)
                 || hit(PADDR, pcrc_pkg::OFS_SUM)
                 || hit(PADDR, pcrc_pkg::OFS_DATA);

    // stall writes while earlier bytes remain.
    // the last byte and a new data word may overlap, so DMA streams.
    always_comb
    begin
        if (PSEL && PWRITE && hit(PADDR, pcrc_pkg::OFS_DATA))
            PREADY = (cnt <= 3'd1);
        else if (PSEL && PWRITE)
            PREADY = (cnt == 3'd0);
        else
            PREADY = 1'b1;
    end

    // The sum is read-only; writing it or an unmapped word is an error.
    assign PSLVERR = acc_ph && (!mapped
                  || (PWRITE && hit(PADDR, pcrc_pkg::OFS_SUM)));
    assign wr_data = acc_ph && PREADY && PWRITE
                  && hit(PADDR, pcrc_pkg::OFS_DATA);
    assign wr_seed = acc_ph && PREADY && PWRITE
                  && hit(PADDR, pcrc_pkg::OFS_SEED);
    assign wr_mode = acc_ph && PREADY && PWRITE
                  && hit(PADDR, pcrc_pkg::OFS_MODE);

    // ------------------------------------------------------------------
    // Engine datapath
    // ------------------------------------------------------------------

    // the mode field picks one of three polynomials.
    assign sel  = pcrc_pkg::pcrc_sel_t'(mode[pcrc_pkg::MODE_SEL_LSB +: 2]);
    assign wide = (sel == pcrc_pkg::SEL_C32);
    // the reserved code falls back to CCITT so the engine never idles.
    always_comb
    begin
        unique case (sel)
            pcrc_pkg::SEL_CCITT: poly = pcrc_pkg::POLY_CCITT;
            pcrc_pkg::SEL_C16:   poly = pcrc_pkg::POLY_C16;
            pcrc_pkg::SEL_C32:   poly = pcrc_pkg::POLY_C32;
            pcrc_pkg::SEL_RSVD:  poly = pcrc_pkg::POLY_CCITT;
        endcase
    end

    // input reverse and invert act on each byte before folding.
    always_comb
    begin
        cur_byte = shreg[7:0];
        if (mode[pcrc_pkg::MODE_IN_REV])
            cur_byte = rev8(cur_byte);
        if (mode[pcrc_pkg::MODE_IN_INV])
            cur_byte = ~cur_byte;
    end

    pcrc_step u_step
    (
        .crc_in  (crc),
        .data_in (cur_byte),
        .wide    (wide),
        .poly    (poly),
        .crc_out (step_out)
    );

    // A 16-bit remainder lands in the top half once the word is mirrored.
    assign sum_rev = rev32(crc);

    // the read view applies the output settings within the width.
    // sum reverse and sum invert are independent of the input ones.
    always_comb
    begin
        sum_view = wide ? crc : {16'h0000, crc[15:0]};
        if (mode[pcrc_pkg::MODE_OUT_REV])
            sum_view = wide ? sum_rev : {16'h0000, sum_rev[31:16]};
        if (mode[pcrc_pkg::MODE_OUT_INV])
            sum_view = wide ? ~sum_view : {16'h0000, ~sum_view[15:0]};
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    always_comb
    begin
        next_mode  = mode;
        next_crc   = crc;
        next_shreg = shreg;
        next_cnt   = cnt;
        next_rdata = rdata;
        if (wr_mode)
            next_mode = PWDATA[pcrc_pkg::MODE_WIDTH-1:0];
        // one byte leaves the shift register per cycle.
        if (cnt != 3'd0)
        begin
            next_crc   = step_out;
            next_shreg = {8'h00, shreg[31:8]};
            next_cnt   = cnt - 3'd1;
        end
        // the seed replaces the remainder; only taken when idle.
        if (wr_seed)
            next_crc = PWDATA;
        // the written lanes are packed down and counted.
        if (wr_data)
        begin
            next_shreg = PWDATA >> {first_lane(PSTRB), 3'b000};
            next_cnt   = nbytes(PSTRB);
        end
        // Read data is caught in the setup cycle so PRDATA is a register.
        if (PSEL && !PENABLE && !PWRITE)
            next_rdata = hit(PADDR, pcrc_pkg::OFS_MODE)
                       ? {26'h0, mode}
                       : hit(PADDR, pcrc_pkg::OFS_SUM) ? sum_view
                       : 32'h0000_0000;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode  <= pcrc_pkg::RST_MODE;
            crc   <= pcrc_pkg::RST_SUM;
            shreg <= 32'h0000_0000;
            cnt   <= 3'd0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            mode  <= next_mode;
            crc   <= next_crc;
            shreg <= next_shreg;
            cnt   <= next_cnt;
            rdata <= next_rdata;
        end
    end

    assign PRDATA = rdata;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    a_mode_select: assert property (wr_mode |=>
        sel == pcrc_pkg::pcrc_sel_t'($past(PWDATA[1:0])))
        else $error("Mode select not stored.");
    a_ccitt_poly: assert property (cnt != 0 && crc == 0
        && cur_byte == 8'h01 && sel == pcrc_pkg::SEL_CCITT
        |=> crc == 32'h0000_1021)
        else $error("CCITT step wrong.");
    a_c16_poly: assert property (cnt != 0 && crc == 0
        && cur_byte == 8'h01 && sel == pcrc_pkg::SEL_C16
        |=> crc == 32'h0000_8005)
        else $error("CRC-16 step wrong.");
    a_c32_poly: assert property (cnt != 0 && crc == 0
        && cur_byte == 8'h01 && sel == pcrc_pkg::SEL_C32
        |=> crc == 32'h04c1_1db7)
        else $error("CRC-32 step wrong.");
    a_in_reverse: assert property (cnt != 0 && shreg[7:0] == 8'h80
        && mode[3:2] == 2'b01 && crc == 0 && sel == pcrc_pkg::SEL_C32
        |=> crc == 32'h04c1_1db7)
        else $error("Input reverse wrong.");
    a_seed_load: assert property (wr_seed |=> crc == $past(PWDATA))
        else $error("Seed not loaded.");
    a_half_write: assert property (wr_data && PSTRB == 4'b0011
        |=> cnt == 3'd2)
        else $error("Half-word byte count wrong.");
    a_word_timing: assert property (wr_data && PSTRB == 4'hf
        |=> cnt == 3'd4 ##1 cnt == 3'd3 ##1 cnt == 3'd2 ##1 cnt == 3'd1)
        else $error("Word not one byte per cycle.");
    a_stream_ok: assert property (PSEL && PWRITE && cnt <= 3'd1
        && hit(PADDR, pcrc_pkg::OFS_DATA) |-> PREADY)
        else $error("Stream stalled needlessly.");
    a_stall_busy: assert property (PSEL && PWRITE && cnt > 3'd1
        |-> !PREADY)
        else $error("Write taken while busy.");
    a_sum_read: assert property (PSEL && !PENABLE && !PWRITE
        && hit(PADDR, pcrc_pkg::OFS_SUM) |=> PRDATA == $past(sum_view))
        else $error("Sum read wrong.");

    c_word_write: cover property (wr_data && PSTRB == 4'hf);
    c_back_to_back: cover property (wr_data ##[1:6] wr_data);
    c_seed_then_data: cover property (wr_seed ##[1:4] wr_data);
    c_sum_read: cover property (acc_ph && !PWRITE
        && hit(PADDR, pcrc_pkg::OFS_SUM) && cnt == 0);

endmodule : pcrc_top
`default_nettype wire

// ### dv/pcrc_master.sv
// Bus-side model of the processor or DMA channel that feeds the generator.
`timescale 1ns/100ps
`default_nettype none
module pcrc_master
(
    // Clock
    input  wire logic        clk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Answer of the last transfer and the wait states it cost.
    logic [31:0] rdata;
    logic        err;
    int          waits;

    // Bus idle from time zero.
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end

    // ------------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------------
    // back to back
    // Select stays up at the end, so chained calls stream words with no
    // idle cycle, as a DMA channel does; idle() releases the bus.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        waits = -1;
        do
        begin
            @(posedge clk);
            waits++;
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
    endtask : xfer

    // Release the bus for a number of cycles.
    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
endmodule : pcrc_master
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the checksum generator over APB.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk;
    logic        arst_n;
    wire         psel, penable, pwrite, pready, pslverr;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [3:0]  pstrb;
    int          n_errors;
    int          check_count;
    int          cycles;
    logic [31:0] last_sum;
    logic [5:0]  modes [11] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08,
                                6'h10, 6'h20, 6'h3c, 6'h3e, 6'h3d,
                                6'h03};
    logic [7:0]  bytes [7] = '{8'hcd, 8'hab, 8'h34, 8'h12, 8'h0f,
                               8'h5a, 8'hc3};

    pcrc_top dut (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));
    pcrc_master m (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock and hang limit; a full run needs well under a thousand cycles.
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        m.xfer(1'b0, a, 32'h0000_0000, 4'h0);
        check(m.rdata, exp);
    endtask : rd

    // Reference fold of one byte, MSB first, after the input settings.
    function automatic logic [31:0] fold(input logic [31:0] c,
                                         input logic [7:0] b,
                                         input logic [5:0] md);
        logic [31:0] p;
        logic        fb;
        int          w;
        w = (md[1:0] == 2'b10) ? 32 : 16;
        p = (md[1:0] == 2'b10) ? pcrc_pkg::POLY_C32 :
            (md[1:0] == 2'b01) ? pcrc_pkg::POLY_C16 : pcrc_pkg::POLY_CCITT;
        if (md[2])
            b = {<<{b}};
        if (md[3])
            b = ~b;
        for (int i = 7; i >= 0; i--)
        begin
            fb = c[w-1] ^ b[i];
            c = c << 1;
            if (fb)
                c = c ^ p;
        end
        if (w == 16)
            c[31:16] = 16'h0000;
        return c;
    endfunction : fold

    // Output reverse within the active width, then complement.
    function automatic logic [31:0] outx(input logic [31:0] c,
                                         input logic [5:0] md);
        logic [31:0] r;
        r = c;
        if (md[4])
            r = (md[1:0] == 2'b10) ? {<<{c}} : ({<<{c}} >> 16);
        if (md[5])
            r = ~r;
        if (md[1:0] != 2'b10)
            r[31:16] = 16'h0000;
        return r;
    endfunction : outx

    // Seed, stream a word, a half word and a byte, then read back.
    task automatic run(input logic [5:0] md, input logic [31:0] seed);
        logic [31:0] c;
        int          w1;
        int          w2;
        m.xfer(1'b1, pcrc_pkg::OFS_MODE, {26'h0, md}, 4'hf);
        m.xfer(1'b1, pcrc_pkg::OFS_SEED, seed, 4'hf);
        m.xfer(1'b1, pcrc_pkg::OFS_DATA, 32'h1234_abcd, 4'hf);
        m.xfer(1'b1, pcrc_pkg::OFS_DATA, 32'h0000_5a0f, 4'h3);
        w1 = m.waits;
        m.xfer(1'b1, pcrc_pkg::OFS_DATA, 32'h0000_00c3, 4'h1);
        w2 = m.waits;
        m.idle(6);
        c = (md[1:0] == 2'b10) ? seed : {16'h0000, seed[15:0]};
        foreach (bytes[i])
            c = fold(c, bytes[i], md);
        check(32'(w1), 32'h2);
        check(32'(w2), 32'h0);
        rd(pcrc_pkg::OFS_MODE, {26'h0, md});
        last_sum = outx(c, md);
        rd(pcrc_pkg::OFS_SUM, last_sum);
    endtask : run

    // Zero seed and one byte: the remainder must equal the polynomial.
    task automatic unit(input logic [5:0] md, input logic [7:0] b,
                        input logic [31:0] exp);
        m.xfer(1'b1, pcrc_pkg::OFS_MODE, {26'h0, md}, 4'hf);
        m.xfer(1'b1, pcrc_pkg::OFS_SEED, 32'h0000_0000, 4'hf);
        m.xfer(1'b1, pcrc_pkg::OFS_DATA, {24'h0, b}, 4'h1);
        m.idle(2);
        rd(pcrc_pkg::OFS_SUM, exp);
    endtask : unit

    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk         = 1'b0;
        arst_n      = 1'b0;
        n_errors    = 0;
        check_count = 0;
        cycles      = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(pcrc_pkg::OFS_MODE, 32'h0000_0000);
        rd(pcrc_pkg::OFS_SUM, 32'h0000_0000);
        unit(6'h00, 8'h01, 32'h0000_1021);
        unit(6'h01, 8'h01, 32'h0000_8005);
        unit(6'h02, 8'h01, 32'h04c1_1db7);
        unit(6'h06, 8'h80, 32'h04c1_1db7);
        foreach (modes[i])
            run(modes[i], modes[i][0] ? 32'hffff_ffff : 32'h1d0f_5a5a);
        // A refused write to the sum must leave it untouched.
        m.xfer(1'b1, pcrc_pkg::OFS_SUM, 32'h0bad_f00d, 4'hf);
        check({31'h0, m.err}, 32'h1);
        m.xfer(1'b0, 12'h010, 32'h0000_0000, 4'h0);
        check({31'h0, m.err}, 32'h1);
        m.idle(2);
        rd(pcrc_pkg::OFS_SUM, last_sum);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
